// *** hdl/uxr_pkg.sv ***
/*
 * Shared constants and carrier types of the extended register access unit
 * of one UART channel. Assumes a byte-wide register port with 3 address bits.
 */
package uxr_pkg;

    // =====================================================================
    // register offsets on the 3-bit register port
    localparam logic [2:0] ADDR_DATA = 3'h0; // rx/tx data, divisor low, page select
    localparam logic [2:0] ADDR_IER = 3'h1; // int enable, divisor high, add. feature
    localparam logic [2:0] ADDR_ISR = 3'h2; // int status / fifo control, enh. feature
    localparam logic [2:0] ADDR_LCR = 3'h3;
    localparam logic [2:0] ADDR_MCR = 3'h4; // also tx trigger on the extended page
    localparam logic [2:0] ADDR_LSR = 3'h5; // also tx count, rx trigger
    localparam logic [2:0] ADDR_CNT_RX = 3'h6;
    localparam logic [2:0] ADDR_SPR = 3'h7; // also flow status

    // =====================================================================
    // special values and field positions
    localparam logic [7:0] LCR_EXT_KEY = 8'hBF;
    localparam logic [7:0] PSR_PAGE_EXT = 8'hA5;
    localparam logic [7:0] PSR_PAGE_DEF = 8'hA4;
    localparam int LCR_DLAB_BIT = 7;
    localparam int MCR_ALT_BIT = 6;
    localparam int MCR_XOFF_BIT = 2;
    localparam int MCR_PRESC_BIT = 7;
    localparam int EFR_MCR7_EN_BIT = 4;
    localparam int AFR_FIFO256_BIT = 0;
    localparam int FCR_FIFO_EN_BIT = 0;
    localparam int IER_RX_BIT = 0;
    localparam int IER_TX_BIT = 1;
    localparam int ISR_TXEMPTY_BIT = 7;
    localparam int ISR_RXFULL_BIT = 6;
    localparam logic [5:0] ISR_CODE_RX = 6'h04;
    localparam logic [5:0] ISR_CODE_TX = 6'h02;
    localparam logic [5:0] ISR_CODE_NONE = 6'h01;
    localparam logic [8:0] FIFO_DEPTH = 9'h100;

    // =====================================================================
    // reset values
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_DIV = 8'hFF;
    localparam logic [7:0] RST_TRIG = 8'h80;

    // =====================================================================
    // prescaler
    localparam logic [1:0] PRESC_DIV4_LAST = 2'h3;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [2:0] addr;
        logic [7:0] wdata;
    } uxr_req_t;

    typedef struct packed {
        logic [1:0] word_len;
        logic two_stop;
        logic parity_en;
        logic even_parity;
    } uxr_fmt_t;

endpackage : uxr_pkg

// *** hdl/uxr_buf2.sv ***
/*
 * Two-entry buffer with valid/ready on both sides.
 * Assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none

module uxr_buf2 #(
    parameter int W = 8
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);

    logic [W-1:0] mem_q [2];
    logic wp_q;
    logic rp_q;
    logic [1:0] cnt_q;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign in_ready = (cnt_q != 2'h2);
    assign out_valid = (cnt_q != 2'h0);
    assign out_data = mem_q[rp_q];

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            wp_q <= 1'b0;
            rp_q <= 1'b0;
            cnt_q <= 2'h0;
        end else begin
            if (push) wp_q <= ~wp_q;
            if (pop) rp_q <= ~rp_q;
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (push) mem_q[wp_q] <= in_data;
    end

endmodule : uxr_buf2

`default_nettype wire

// *** hdl/uxr_regs.sv ***
/*
 * Register access and paging of one UART channel with a 256-byte fifo mode.
 * Assumes the fifos, serialiser and flow logic sit outside on the same clock.
 *
// Summary of operation
// [R1] line control 80h maps divisor low/high bytes; host writes 0001h then restores.
// [R2] line control BFh exposes enhanced feature and page select instead of normals.
// [R3] page A5h shows additional feature and trigger regs; A4h default; 01h sets 256 mode.
// [R4] line control 03h selects eight data bits, no parity, one stop.
// [R5] interrupt enable 03h enables receive and transmit-empty interrupts.
// [R6] receive interrupt pending reads status low six bits as 00_0100.
// [R7] transmit interrupt pending reads 00_0010; host ignores other codes.
// [R8] in 256 mode status bit 7 flags transmit fifo empty.
// [R9] in 256 mode status bit 6 flags receive fifo full with 256 chars.
// [R10] those bits are valid only with fifo enable and 256 mode selected.
// [R11] modem control bit 6 with line control not BFh maps transmit count.
// [R12] modem control bit 6 maps receive count, giving waiting characters.
// [R13] xoff re-transmit enabled by modem control write with bits 6 and 2 set.
// [R14] xoff re-transmit disabled by write with bit 2 clear, bit 6 set.
// [R15] clearing modem control bit 6 hides counts, bit 2 normal again.
// [R16] modem control bit 7 writable only while enhanced feature bit 4 set.
// [R17] modem control bit 7 selects prescaler divide by 1 or by 4.
// [R18] host sends 128 chars if empty or count above 128, else count.
// [R19] host reads 256 chars if full, else receive count.
// [R20] modem control bit 6 with line control bit 7 clear maps flow status.
// [R21] leaving 80h or BFh restores normal map, extended contents unchanged.
 */
`timescale 1ns/1ps
`default_nettype none

module uxr_regs (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire uxr_pkg::uxr_req_t req,
    output logic req_ready,
    output logic [7:0] rdata,
    output logic tx_valid,
    input wire logic tx_ready,
    output logic [7:0] tx_data,
    input wire logic rx_valid,
    output logic rx_ready,
    input wire logic [7:0] rx_data,
    input wire logic [8:0] tx_space,
    input wire logic tx_fifo_empty,
    input wire logic [8:0] rx_count,
    input wire logic [7:0] flow_status,
    output logic [15:0] divisor,
    output uxr_pkg::uxr_fmt_t char_fmt,
    output logic [7:0] fifo_ctrl,
    output logic [7:0] enh_feature,
    output logic [7:0] tx_trigger,
    output logic [7:0] rx_trigger,
    output logic fifo_256_mode,
    output logic xoff_retx_en,
    output logic prescale_div4,
    output logic baud_tick,
    output logic int_pending
);

    // =====================================================================
    // storage
    logic [7:0] lcr_q;
    logic [7:0] dll_q;
    logic [7:0] dlm_q;
    logic [7:0] ier_q;
    logic [7:0] fcr_q;
    logic [7:0] mcr_q;
    logic [7:0] mcr_d;
    logic [7:0] spr_q;
    logic [7:0] psr_q;
    logic [7:0] efr_q;
    logic [7:0] afr_q;
    logic [7:0] ttr_q;
    logic [7:0] rtr_q;
    logic xoff_q;
    logic [7:0] rdata_q;
    logic [1:0] presc_q;
    logic tick_q;

    // =====================================================================
    // map decode
    wire [2:0] a = req.addr;
    wire ext = (lcr_q == uxr_pkg::LCR_EXT_KEY); // [R2]
    wire dl = lcr_q[uxr_pkg::LCR_DLAB_BIT] && !ext; // [R1]
    wire norm = !ext && !lcr_q[uxr_pkg::LCR_DLAB_BIT]; // [R21]
    wire page5 = ext && (psr_q == uxr_pkg::PSR_PAGE_EXT); // [R3]
    wire alt = mcr_q[uxr_pkg::MCR_ALT_BIT] && !ext; // [R11] [R15]
    wire fsr_map = alt && !lcr_q[uxr_pkg::LCR_DLAB_BIT]; // [R20]

    wire sel_dll = dl && (a == uxr_pkg::ADDR_DATA);
    wire sel_dlm = dl && (a == uxr_pkg::ADDR_IER);
    wire sel_data = norm && (a == uxr_pkg::ADDR_DATA);
    wire sel_ier = norm && (a == uxr_pkg::ADDR_IER);
    wire sel_psr = ext && (a == uxr_pkg::ADDR_DATA); // [R2]
    wire sel_afr = page5 && (a == uxr_pkg::ADDR_IER); // [R3]
    wire sel_efr = ext && !page5 && (a == uxr_pkg::ADDR_ISR); // [R2]
    wire sel_ttr = page5 && (a == uxr_pkg::ADDR_MCR); // [R3]
    wire sel_rtr = page5 && (a == uxr_pkg::ADDR_LSR);
    wire sel_isr = !ext && (a == uxr_pkg::ADDR_ISR);
    wire sel_lcr = (a == uxr_pkg::ADDR_LCR);
    wire sel_mcr = !ext && (a == uxr_pkg::ADDR_MCR);
    wire sel_tcr = alt && (a == uxr_pkg::ADDR_LSR); // [R11]
    wire sel_lsr = !ext && !alt && (a == uxr_pkg::ADDR_LSR);
    wire sel_rcr = alt && (a == uxr_pkg::ADDR_CNT_RX); // [R12]
    wire sel_fsr = fsr_map && (a == uxr_pkg::ADDR_SPR); // [R20]
    wire sel_spr = !ext && !fsr_map && (a == uxr_pkg::ADDR_SPR);

    wire wr_ok = req.wr && req_ready;

    // =====================================================================
    // transmit path: a stalled serialiser holds off data writes once the two-entry buffer is full
    logic buf_in_ready;
    logic buf_valid;
    wire thr_push = req.wr && sel_data;

    assign req_ready = !(sel_data && req.wr) || buf_in_ready;
    assign tx_valid = buf_valid;

    uxr_buf2 #(
        .W(8)
    ) u_txbuf (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .in_valid(thr_push),
        .in_ready(buf_in_ready),
        .in_data(req.wdata),
        .out_valid(buf_valid),
        .out_ready(tx_ready),
        .out_data(tx_data)
    );

    // a receive data read pops one character in the read cycle
    assign rx_ready = req.rd && sel_data && rx_valid;

    // =====================================================================
    // interrupt status
    wire mode256 = fcr_q[uxr_pkg::FCR_FIFO_EN_BIT] && afr_q[uxr_pkg::AFR_FIFO256_BIT]; // [R10]
    wire [8:0] rx_thr = (rtr_q == 8'h00) ? 9'h001 : {1'b0, rtr_q};
    wire rx_src = ier_q[uxr_pkg::IER_RX_BIT] && (rx_count >= rx_thr) && rx_valid; // [R5]
    wire tx_src = ier_q[uxr_pkg::IER_TX_BIT] && !buf_valid
        && (tx_space >= {1'b0, ttr_q}); // [R5]
    wire [5:0] isr_code = rx_src ? uxr_pkg::ISR_CODE_RX // [R6]
        : tx_src ? uxr_pkg::ISR_CODE_TX // [R7]
        : uxr_pkg::ISR_CODE_NONE;
    wire isr_txe = mode256 && tx_fifo_empty && !buf_valid; // [R8]
    wire isr_rxf = mode256 && (rx_count == uxr_pkg::FIFO_DEPTH); // [R9]
    wire [7:0] isr_val = {isr_txe, isr_rxf, isr_code};

    wire [7:0] lsr_val = {1'b0, tx_fifo_empty && !buf_valid, buf_in_ready, 4'h0, rx_valid};

    // =====================================================================
    // read selection
    wire [7:0] rd_mux =
        sel_dll ? dll_q :
        sel_dlm ? dlm_q : // [R1]
        sel_psr ? psr_q :
        sel_afr ? afr_q :
        sel_efr ? efr_q :
        sel_ttr ? ttr_q :
        sel_rtr ? rtr_q :
        sel_data ? rx_data :
        sel_ier ? ier_q :
        sel_isr ? isr_val :
        sel_lcr ? lcr_q :
        sel_mcr ? mcr_q :
        sel_tcr ? tx_space[7:0] : // [R11]
        sel_rcr ? rx_count[7:0] : // [R12]
        sel_lsr ? lsr_val :
        sel_fsr ? flow_status : // [R20]
        sel_spr ? spr_q : 8'h00;

    // =====================================================================
    // modem control write
    always_comb begin
        mcr_d = mcr_q;
        if (wr_ok && sel_mcr) begin
            mcr_d = req.wdata;
            // bit 7 is locked unless the enhanced unlock bit is set
            if (!efr_q[uxr_pkg::EFR_MCR7_EN_BIT]) begin
                mcr_d[uxr_pkg::MCR_PRESC_BIT] = mcr_q[uxr_pkg::MCR_PRESC_BIT]; // [R16]
            end
            // bit 2 steers xoff re-transmit only while the write keeps the alternate map
            if (alt && req.wdata[uxr_pkg::MCR_ALT_BIT]) begin
                mcr_d[uxr_pkg::MCR_XOFF_BIT] = mcr_q[uxr_pkg::MCR_XOFF_BIT]; // [R15]
            end
        end
    end

    // =====================================================================
    // register writes
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            lcr_q <= uxr_pkg::RST_ZERO;
            dll_q <= uxr_pkg::RST_DIV;
            dlm_q <= uxr_pkg::RST_DIV;
            ier_q <= uxr_pkg::RST_ZERO;
            fcr_q <= uxr_pkg::RST_ZERO;
            mcr_q <= uxr_pkg::RST_ZERO;
            spr_q <= uxr_pkg::RST_ZERO;
        end else begin
            mcr_q <= mcr_d;
            if (wr_ok && sel_lcr) lcr_q <= req.wdata; // [R4] [R21]
            if (wr_ok && sel_dll) dll_q <= req.wdata; // [R1]
            if (wr_ok && sel_dlm) dlm_q <= req.wdata; // [R1]
            if (wr_ok && sel_ier) ier_q <= req.wdata; // [R5]
            if (wr_ok && sel_isr) fcr_q <= req.wdata; // [R10]
            if (wr_ok && sel_spr) spr_q <= req.wdata;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            psr_q <= uxr_pkg::RST_ZERO;
            efr_q <= uxr_pkg::RST_ZERO;
            afr_q <= uxr_pkg::RST_ZERO;
            ttr_q <= uxr_pkg::RST_TRIG;
            rtr_q <= uxr_pkg::RST_TRIG;
            xoff_q <= 1'b0;
        end else begin
            if (wr_ok && sel_psr) psr_q <= req.wdata; // [R3]
            if (wr_ok && sel_efr) efr_q <= req.wdata; // [R2]
            if (wr_ok && sel_afr) afr_q <= req.wdata; // [R3]
            if (wr_ok && sel_ttr) ttr_q <= req.wdata;
            if (wr_ok && sel_rtr) rtr_q <= req.wdata;
            if (wr_ok && sel_mcr && alt && req.wdata[uxr_pkg::MCR_ALT_BIT]) begin
                xoff_q <= req.wdata[uxr_pkg::MCR_XOFF_BIT]; // [R13] [R14]
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            rdata_q <= uxr_pkg::RST_ZERO;
        end else if (req.rd) begin
            rdata_q <= rd_mux;
        end
    end

    // =====================================================================
    // baud prescaler
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            presc_q <= 2'h0;
            tick_q <= 1'b0;
        end else begin
            if (!mcr_q[uxr_pkg::MCR_PRESC_BIT] || presc_q == uxr_pkg::PRESC_DIV4_LAST) begin
                presc_q <= 2'h0; // [R17]
            end else begin
                presc_q <= presc_q + 2'h1;
            end
            tick_q <= !mcr_q[uxr_pkg::MCR_PRESC_BIT]
                || (presc_q == uxr_pkg::PRESC_DIV4_LAST); // [R17]
        end
    end

    // =====================================================================
    // outputs
    assign rdata = rdata_q;
    assign divisor = {dlm_q, dll_q};
    assign char_fmt = '{word_len: lcr_q[1:0], two_stop: lcr_q[2], // [R4]
        parity_en: lcr_q[3], even_parity: lcr_q[4]};
    assign fifo_ctrl = fcr_q;
    assign enh_feature = efr_q;
    assign tx_trigger = ttr_q;
    assign rx_trigger = rtr_q;
    assign fifo_256_mode = mode256; // [R3]
    assign xoff_retx_en = xoff_q;
    assign prescale_div4 = mcr_q[uxr_pkg::MCR_PRESC_BIT];
    assign baud_tick = tick_q;
    assign int_pending = rx_src || tx_src;

    // =====================================================================
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    chk_div_map: assert property ( // [R1]
        (req.rd && dl && a == uxr_pkg::ADDR_IER) |=> (rdata == $past(dlm_q)))
        else $error("divisor high byte not mapped");
    chk_ext_efr: assert property ( // [R2]
        (req.wr && ext && !page5 && a == uxr_pkg::ADDR_ISR) |=> (enh_feature == $past(req.wdata))
            && (fifo_ctrl == $past(fcr_q)))
        else $error("enhanced feature write misrouted");
    chk_page_afr: assert property ( // [R3]
        (req.wr && page5 && a == uxr_pkg::ADDR_IER && req.wdata == 8'h01 && fcr_q[0])
            |=> fifo_256_mode)
        else $error("256 mode not entered");
    chk_lcr_fmt: assert property ( // [R4]
        (req.wr && a == uxr_pkg::ADDR_LCR && req.wdata == 8'h03)
            |=> (char_fmt.word_len == 2'h3) && !char_fmt.parity_en && !char_fmt.two_stop)
        else $error("character format wrong");
    chk_isr_rx: assert property ( // [R6]
        (req.rd && sel_isr && rx_src) |=> (rdata[5:0] == 6'h04))
        else $error("receive code wrong");
    chk_isr_tx: assert property ( // [R7]
        (req.rd && sel_isr && !rx_src && tx_src) |=> (rdata[5:0] == 6'h02))
        else $error("transmit code wrong");
    chk_isr_flags: assert property ( // [R10]
        (req.rd && sel_isr) |=> (rdata[7:6] == 2'b00 || $past(mode256)))
        else $error("fifo flags outside 256 mode");
    chk_tcr_map: assert property ( // [R11]
        (req.rd && mcr_q[6] && lcr_q != 8'hBF && a == uxr_pkg::ADDR_LSR)
            |=> (rdata == $past(tx_space[7:0])))
        else $error("transmit count not mapped");
    chk_xoff_set: assert property ( // [R13] [R14]
        (req.wr && alt && a == uxr_pkg::ADDR_MCR && req.wdata[uxr_pkg::MCR_ALT_BIT])
            |=> (xoff_retx_en == $past(req.wdata[2])) && ($past(mcr_q[2]) == mcr_q[2]))
        else $error("xoff control wrong");
    chk_xoff_hold: assert property ( // [R15]
        !(req.wr && alt && a == uxr_pkg::ADDR_MCR && req.wdata[uxr_pkg::MCR_ALT_BIT])
            |=> $stable(xoff_retx_en))
        else $error("xoff control changed outside its write");
    chk_rcr_map: assert property ( // [R12]
        (req.rd && mcr_q[6] && lcr_q != 8'hBF && a == uxr_pkg::ADDR_CNT_RX)
            |=> (rdata == $past(rx_count[7:0])))
        else $error("receive count not mapped");
    chk_fsr_map: assert property ( // [R20]
        (req.rd && mcr_q[6] && !lcr_q[7] && a == uxr_pkg::ADDR_SPR)
            |=> (rdata == $past(flow_status)))
        else $error("flow status not mapped");
    chk_rxfull_flag: assert property ( // [R9]
        (req.rd && sel_isr && fifo_256_mode && rx_count == uxr_pkg::FIFO_DEPTH)
            |=> rdata[uxr_pkg::ISR_RXFULL_BIT])
        else $error("receive full flag missing");
    chk_txempty_flag: assert property ( // [R8]
        (req.rd && sel_isr && fifo_256_mode && tx_fifo_empty && !tx_valid)
            |=> rdata[uxr_pkg::ISR_TXEMPTY_BIT])
        else $error("transmit empty flag missing");
    chk_page_default: assert property ( // [R3]
        (req.wr && ext && a == uxr_pkg::ADDR_DATA && req.wdata == uxr_pkg::PSR_PAGE_DEF)
            |=> !page5)
        else $error("default page not restored");
    chk_mcr7_lock: assert property ( // [R16]
        !efr_q[4] |=> $stable(prescale_div4))
        else $error("prescaler changed while locked");
    chk_presc_div4: assert property ( // [R17]
        (prescale_div4 && $past(prescale_div4, 4) && baud_tick)
            |=> (!baud_tick || !$past(prescale_div4)) [*3])
        else $error("divide by 4 tick spacing wrong");

endmodule : uxr_regs

`default_nettype wire

// *** dv/uxr_far_model.sv ***
/*
 * Far-side model of the register block: a tx fifo sink that can stall and
 * an rx character source. Assumes the same clock and reset as the block.
 */
`timescale 1ns/1ps
`default_nettype none

module uxr_far_model (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic [7:0] tx_data,
    input wire logic stall,
    output logic rx_valid,
    input wire logic rx_ready,
    output logic [7:0] rx_data,
    input wire logic load,
    input wire logic [7:0] load_data
);
    // =====================================================================
    // tx sink and rx source
    logic [7:0] got [$];
    logic [7:0] last_q;
    assign tx_ready = !stall;
    // released data shows the inverse, so a stale read cannot pass
    assign rx_data = rx_valid ? last_q : ~last_q;
    always @(posedge clk_sys) begin
        if (!rstn) begin
            rx_valid <= 1'b0;
            last_q <= 8'h00;
        end else begin
            if (tx_valid && tx_ready) begin
                got.push_back(tx_data);
            end
            if (load) begin
                rx_valid <= 1'b1;
                last_q <= load_data;
            end else if (rx_ready) begin
                rx_valid <= 1'b0;
            end
        end
    end
endmodule : uxr_far_model

`default_nettype wire

// *** dv/tb.sv ***
/*
 * Self-checking bench of the register block: byte accesses on the
 * register port, paging, status codes, prescaler and the tx buffer.
 * Assumes a 10 MHz clock and inputs driven at the falling edge.
 */
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    uxr_pkg::uxr_req_t req = '0;
    logic req_ready, tx_valid, tx_ready, rx_valid, rx_ready, ok;
    logic [7:0] rdata, tx_data, rx_data, fifo_ctrl, enh_feature, tx_trigger, rx_trigger;
    logic [8:0] tx_space = 9'h100;
    logic [8:0] rx_count = 9'h000;
    logic tx_fifo_empty = 1'b1;
    logic [7:0] flow_status = 8'h00;
    logic [15:0] divisor;
    uxr_pkg::uxr_fmt_t char_fmt;
    logic fifo_256_mode, xoff_retx_en, prescale_div4, baud_tick, int_pending;
    logic stall = 1'b0;
    logic load = 1'b0;
    logic [7:0] load_data = 8'h00;
    int error_cnt = 0;
    int check_count = 0;
    int n;

    always #50 clk_sys = ~clk_sys;

    uxr_regs i_uxr_regs (.clk_sys(clk_sys), .rstn(rstn), .req(req), .req_ready(req_ready),
        .rdata(rdata), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data), .tx_space(tx_space),
        .tx_fifo_empty(tx_fifo_empty), .rx_count(rx_count), .flow_status(flow_status),
        .divisor(divisor), .char_fmt(char_fmt), .fifo_ctrl(fifo_ctrl),
        .enh_feature(enh_feature), .tx_trigger(tx_trigger), .rx_trigger(rx_trigger),
        .fifo_256_mode(fifo_256_mode), .xoff_retx_en(xoff_retx_en),
        .prescale_div4(prescale_div4), .baud_tick(baud_tick), .int_pending(int_pending));

    uxr_far_model i_uxr_far_model (.clk_sys(clk_sys), .rstn(rstn), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .tx_data(tx_data), .stall(stall), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .rx_data(rx_data), .load(load), .load_data(load_data));

    // =====================================================================
    // access and compare tasks
    task automatic results();
        if (error_cnt == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : results

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // request held one full cycle; acceptance sampled before the taking edge
    task automatic acc(input logic w, input logic r, input logic [2:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        req <= '{wr: w, rd: r, addr: a, wdata: d};
        #40;
        ok = req_ready;
        @(negedge clk_sys);
        req <= '0;
    endtask : acc

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        acc(1'b1, 1'b0, a, d);
    endtask : wr

    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        acc(1'b0, 1'b1, a, 8'h00);
        chk({8'h00, rdata}, {8'h00, exp});
    endtask : rd

    // counts ticks over eight cycles after one settling cycle
    task automatic ticks(input int exp);
        n = 0;
        @(negedge clk_sys);
        repeat (8) begin
            @(negedge clk_sys);
            if (baud_tick === 1'b1) n++;
        end
        chk(16'(n), 16'(exp));
    endtask : ticks

    // =====================================================================
    // main sequence
    initial begin
        repeat (16) @(negedge clk_sys);
        rstn <= 1'b1;
        chk(divisor, 16'hFFFF);
        chk({tx_trigger, rx_trigger}, 16'h8080);
        chk({enh_feature, fifo_ctrl}, 16'h0000);
        wr(3'h4, 8'h80);
        chk({15'h0000, prescale_div4}, 16'h0000);
        wr(3'h3, 8'h80);
        wr(3'h0, 8'h01);
        wr(3'h1, 8'h00);
        chk(divisor, 16'h0001);
        rd(3'h1, 8'h00);
        wr(3'h3, 8'h03);
        chk({11'h000, char_fmt}, 16'h0018);
        chk(divisor, 16'h0001);
        wr(3'h2, 8'h01);
        chk({15'h0000, fifo_256_mode}, 16'h0000);
        wr(3'h3, 8'hBF);
        wr(3'h0, 8'hA5);
        wr(3'h4, 8'h20);
        wr(3'h5, 8'h80);
        wr(3'h1, 8'h01);
        rd(3'h4, 8'h20);
        wr(3'h0, 8'hA4);
        wr(3'h2, 8'h10);
        rd(3'h2, 8'h10);
        wr(3'h3, 8'h03);
        chk({tx_trigger, enh_feature}, 16'h2010);
        chk({15'h0000, fifo_256_mode}, 16'h0001);
        wr(3'h2, 8'h00);
        chk({15'h0000, fifo_256_mode}, 16'h0000);
        wr(3'h2, 8'h01);
        chk({15'h0000, fifo_256_mode}, 16'h0001);
        wr(3'h4, 8'h80);
        chk({15'h0000, prescale_div4}, 16'h0001);
        ticks(2);
        wr(3'h4, 8'h00);
        ticks(8);
        // status codes: rx full and tx empty at once, then tx only
        wr(3'h1, 8'h03);
        @(negedge clk_sys);
        load <= 1'b1;
        load_data <= 8'h5A;
        rx_count <= 9'h100;
        @(negedge clk_sys);
        load <= 1'b0;
        chk({15'h0000, int_pending}, 16'h0001);
        rd(3'h2, 8'hC4);
        rd(3'h0, 8'h5A);
        @(negedge clk_sys);
        rx_count <= 9'h000;
        rd(3'h2, 8'h82);
        // alternate map
        @(negedge clk_sys);
        tx_space <= 9'h0A3;
        rx_count <= 9'h017;
        flow_status <= 8'h3C;
        wr(3'h4, 8'h40);
        rd(3'h5, 8'hA3);
        rd(3'h6, 8'h17);
        rd(3'h7, 8'h3C);
        wr(3'h4, 8'h44);
        chk({15'h0000, xoff_retx_en}, 16'h0001);
        wr(3'h4, 8'h40);
        chk({15'h0000, xoff_retx_en}, 16'h0000);
        wr(3'h4, 8'h44);
        wr(3'h4, 8'h00);
        rd(3'h6, 8'h00);
        chk({15'h0000, xoff_retx_en}, 16'h0001);
        // tx buffer: fill against a stalled sink, then drain
        @(negedge clk_sys);
        stall <= 1'b1;
        n = 0;
        wr(3'h0, 8'h11);
        if (ok === 1'b1) n++;
        wr(3'h0, 8'h22);
        if (ok === 1'b1) n++;
        wr(3'h0, 8'h33);
        if (ok === 1'b1) n++;
        chk(16'(n), 16'h0002);
        @(negedge clk_sys);
        stall <= 1'b0;
        for (int i = 0; i < 20 && i_uxr_far_model.got.size() < 2; i++) @(negedge clk_sys);
        if (i_uxr_far_model.got.size() < 2) begin
            error_cnt++;
        end else begin
            repeat (4) @(negedge clk_sys);
            chk(16'(i_uxr_far_model.got.size()), 16'h0002);
            chk({i_uxr_far_model.got[0], i_uxr_far_model.got[1]}, 16'h1122);
            // tx service: empty flag set, so one full block of 128
            rd(3'h2, 8'h82);
            for (int i = 0; i < 128; i++) wr(3'h0, 8'(i));
            repeat (4) @(negedge clk_sys);
            chk(16'(i_uxr_far_model.got.size()), 16'h0082);
            chk({8'h00, i_uxr_far_model.got[129]}, 16'h007F);
            // rx service below the full mark: read what the count reports
            @(negedge clk_sys);
            load <= 1'b1;
            load_data <= 8'hA7;
            rx_count <= 9'h001;
            @(negedge clk_sys);
            load <= 1'b0;
            wr(3'h4, 8'h40);
            rd(3'h6, 8'h01);
            wr(3'h4, 8'h00);
            rd(3'h0, 8'hA7);
        end
        results();
    end
endmodule : tb

`default_nettype wire
